// file: hdl/lmpio_map.svh
// Register offsets, reset values and field constants of the macrocell and port block.
// Assumes the includer supplies the host register window and clk_in timing.
`ifndef LMPIO_MAP_SVH
`define LMPIO_MAP_SVH

// -----------------------------------------------------------------
// Register offsets inside the port register window
// -----------------------------------------------------------------
`define LMPIO_OFF_DIN_A 8'h00
`define LMPIO_OFF_DIN_B 8'h01
`define LMPIO_OFF_CTRL_A 8'h02
`define LMPIO_OFF_CTRL_B 8'h03
`define LMPIO_OFF_DOUT_A 8'h04
`define LMPIO_OFF_DOUT_B 8'h05
`define LMPIO_OFF_DIR_A 8'h06
`define LMPIO_OFF_DIR_B 8'h07
`define LMPIO_OFF_IMC_A 8'h0a
`define LMPIO_OFF_IMC_B 8'h0b
`define LMPIO_OFF_DIN_C 8'h10
`define LMPIO_OFF_DIN_D 8'h11
`define LMPIO_OFF_DOUT_C 8'h12
`define LMPIO_OFF_DOUT_D 8'h13
`define LMPIO_OFF_DIR_C 8'h14
`define LMPIO_OFF_DIR_D 8'h15
`define LMPIO_OFF_IMC_C 8'h18
`define LMPIO_OFF_OMC_A 8'h20
`define LMPIO_OFF_OMC_B 8'h21
`define LMPIO_OFF_MASK_A 8'h22
`define LMPIO_OFF_MASK_B 8'h23

// -----------------------------------------------------------------
// Reset values and widths
// -----------------------------------------------------------------
`define LMPIO_RST_BYTE 8'h00
`define LMPIO_PORTD_MASK 8'h07
`define LMPIO_PORTD_BITS 3

`endif

// file: hdl/lmpio_pkg.sv
// Types shared by the macrocell and port block.
// Assumes nothing beyond a SystemVerilog compiler.
package lmpio_pkg;
    // Input cell operating mode, fixed at programming time
    typedef enum logic [1:0] {
        LMPIO_IMC_PASS = 2'h0,
        LMPIO_IMC_LATCH = 2'h1,
        LMPIO_IMC_REG = 2'h3
    } lmpio_imc_mode_t;
    // One port-wide byte
    typedef logic [7:0] lmpio_byte_t;
endpackage : lmpio_pkg

// file: hdl/lmpio_pt_alloc.sv
// Product-term allocator: per-cell sum of own and borrowed terms.
// Assumes static configuration and terms synchronous to clk_in.
`timescale 1ns/1ps
module lmpio_pt_alloc (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [63:0] native_pt_in,
    input wire logic [63:0] cfg_use_native_in,
    input wire logic [127:0] cfg_borrow_in,
    input wire logic [15:0] cfg_expand_in,
    input wire logic [15:0] cfg_invert_in,
    output logic [15:0] sum_out,
    output logic [15:0] consumed_out
);
    logic [15:0] raw; // Own plus borrowed terms
    logic [15:0] exp_q; // Expansion path, one cycle slower
    logic [15:0] exp_d;

    // -------------------------------------------------------------
    // Per-cell term gathering
    // -------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < 16; c = c + 1) begin : g_cell
            localparam int GB = (c / 8) * 8;
            localparam int PRV = GB + ((c % 8) + 7) % 8;
            localparam int NXT = GB + ((c % 8) + 1) % 8;
            localparam int NNX = GB + ((c % 8) + 2) % 8;
            // Slot 3 does not exist in the first group
            localparam logic [3:0] NAT = (c < 8) ? 4'h7 : 4'hf;
            // Prev lends all its slots, next only enough to hit the cap
            localparam logic [3:0] NCAP = (c < 8) ? 4'h7 : ((c < 12) ? 4'h1 : 4'h3);
            logic [3:0] own;
            logic [3:0] ok_prv;
            logic [3:0] ok_nxt;
            // A term in use by its owner, or taken by the other
            // neighbour, is never lent twice
            assign own = native_pt_in[c*4 +: 4] & cfg_use_native_in[c*4 +: 4] & NAT;
            assign ok_prv = NAT & ~cfg_use_native_in[PRV*4 +: 4];
            assign ok_nxt = NCAP & ~cfg_use_native_in[NXT*4 +: 4]
                & ~cfg_borrow_in[NNX*8 +: 4];
            assign raw[c] = (|own)
                | (|(native_pt_in[PRV*4 +: 4] & cfg_borrow_in[c*8 +: 4] & ok_prv))
                | (|(native_pt_in[NXT*4 +: 4] & cfg_borrow_in[c*8+4 +: 4] & ok_nxt));
            // Cell NXT is swallowed when this cell expands into it
            assign consumed_out[c] = cfg_expand_in[PRV];
            // Expansion adds one register stage of delay
            always_comb begin
                exp_d[c] = cfg_expand_in[c] & raw[NXT];
            end
            assign sum_out[c] = ((raw[c] | exp_q[c]) ^ cfg_invert_in[c])
                & ~consumed_out[c];
        end
    endgenerate

    // Expansion register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            exp_q <= 16'h0000;
        end else begin
            exp_q <= exp_d;
        end
    end
endmodule : lmpio_pt_alloc

// file: hdl/lmpio_top.sv
// Macrocell and I/O port block: output cells, input cells, four ports.
// Assumes a host register window on an 8-bit bus with write, read and
// address strobes, all synchronous to clk_in; cfg_* inputs are static.
`timescale 1ns/1ps
`include "lmpio_map.svh"
module lmpio_top (
    input wire logic clk_in,
    input wire logic srst_in,
    // Host bus
    input wire logic port_register_window_select_in,
    input wire logic [7:0] host_addr_in,
    input wire logic [7:0] host_wdata_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic host_ale_in,
    output logic [7:0] host_rdata_out,
    // Logic array side
    input wire logic [63:0] native_pt_in,
    input wire logic [15:0] omc_clk_pt_in,
    input wire logic [15:0] omc_preset_pt_in,
    input wire logic [15:0] omc_clear_pt_in,
    input wire logic [4:0] imc_pt_in,
    input wire logic [31:0] oe_pt_in,
    input wire logic [1:0] ext_chip_selects_in,
    output logic [15:0] output_logic_cell_out,
    output logic [19:0] input_logic_cell_out,
    // Pins
    input wire logic [7:0] pin_a_in,
    input wire logic [7:0] pin_b_in,
    input wire logic [7:0] pin_c_in,
    input wire logic [2:0] pin_d_in,
    output logic [7:0] pin_a_out,
    output logic [7:0] pin_b_out,
    output logic [7:0] pin_c_out,
    output logic [2:0] pin_d_out,
    output logic [7:0] pin_a_oe_out,
    output logic [7:0] pin_b_oe_out,
    output logic [7:0] pin_c_oe_out,
    output logic [2:0] pin_d_oe_out,
    // Static programming-time configuration
    input wire logic cfg_edge_load_in,
    input wire logic [63:0] cfg_use_native_in,
    input wire logic [127:0] cfg_borrow_in,
    input wire logic [15:0] cfg_expand_in,
    input wire logic [15:0] cfg_invert_in,
    input wire logic [15:0] cfg_comb_in,
    input wire logic [39:0] cfg_imc_mode_in,
    input wire logic [4:0] cfg_imc_ale_in,
    input wire logic [31:0] cfg_pld_out_in,
    input wire logic [31:0] cfg_oe_def_in,
    input wire logic [7:0] cfg_b_grp_in
);

    // -------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------
    logic [3:0][7:0] dout_q; // Output data registers
    logic [3:0][7:0] dout_d;
    logic [3:0][7:0] dir_q; // Direction registers
    logic [3:0][7:0] dir_d;
    logic [1:0][7:0] ctrl_q; // Control, ports A and B only
    logic [1:0][7:0] ctrl_d;
    logic [1:0][7:0] mask_q; // Cell write masks
    logic [1:0][7:0] mask_d;
    logic [7:0] alat_q; // Latched host address
    logic [7:0] alat_d;
    logic wr_q; // Previous write strobe
    logic wr_d;
    logic [7:0] wa_q; // Address held over the strobe
    logic [7:0] wa_d;
    logic [7:0] wd_q; // Data held over the strobe
    logic [7:0] wd_d;
    logic [15:0] omc_q; // Output cell flip-flops
    logic [15:0] omc_d;
    logic [15:0] fb_q; // Cell outputs to array and pins
    logic [15:0] fb_d;
    logic [19:0] imc_q; // Input cell storage
    logic [19:0] imc_d;
    logic [4:0] strb_q; // Previous input strobe level
    logic [4:0] strb_d;
    logic [3:0][7:0] pin_q; // Registered pin drive
    logic [3:0][7:0] pin_d;
    logic [3:0][7:0] oe_q; // Registered pin enables
    logic [3:0][7:0] oe_d;
    logic [7:0] rd_q; // Readback buffer
    logic [7:0] rd_d;
    logic wr_now; // Host write in window this cycle
    logic trail; // Trailing edge of the write strobe
    logic [1:0] ld_hit; // Load request per cell group
    logic [7:0] ld_data; // Data used for a cell load
    logic [15:0] sum; // Allocated sum per cell
    logic [15:0] consumed; // Cell swallowed by expansion
    logic [4:0] strb; // Selected input strobe per nibble
    logic [3:0][7:0] pins; // Pin levels by port
    logic [3:0][7:0] pld; // Array-side source per pin

    assign wr_now = port_register_window_select_in & host_wr_in;
    assign trail = wr_q & ~wr_now;
    assign pins = {5'h00, pin_d_in, pin_c_in, pin_b_in, pin_a_in};

    // -------------------------------------------------------------
    // Product-term allocation
    // -------------------------------------------------------------
    lmpio_pt_alloc u_alloc (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .native_pt_in(native_pt_in),
        .cfg_use_native_in(cfg_use_native_in),
        .cfg_borrow_in(cfg_borrow_in),
        .cfg_expand_in(cfg_expand_in),
        .cfg_invert_in(cfg_invert_in),
        .sum_out(sum),
        .consumed_out(consumed)
    );

    // -------------------------------------------------------------
    // Host strobe capture and address latch
    // -------------------------------------------------------------
    // Holding address and data lets edge loading use the values
    // seen during the strobe, not after it drops
    always_comb begin
        wr_d = wr_now;
        wa_d = wr_now ? host_addr_in : wa_q;
        wd_d = wr_now ? host_wdata_in : wd_q;
        // Transparent while the address strobe is high
        alat_d = host_ale_in ? host_addr_in : alat_q;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr_q <= 1'b0;
            wa_q <= `LMPIO_RST_BYTE;
            wd_q <= `LMPIO_RST_BYTE;
            alat_q <= `LMPIO_RST_BYTE;
        end else begin
            wr_q <= wr_d;
            wa_q <= wa_d;
            wd_q <= wd_d;
            alat_q <= alat_d;
        end
    end

    // -------------------------------------------------------------
    // Port configuration and mask registers
    // -------------------------------------------------------------
    // Written every cycle the strobe stands; repeats are harmless
    always_comb begin
        dout_d = dout_q;
        dir_d = dir_q;
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        if (wr_now) begin
            case (host_addr_in)
                `LMPIO_OFF_DOUT_A: dout_d[0] = host_wdata_in;
                `LMPIO_OFF_DOUT_B: dout_d[1] = host_wdata_in;
                `LMPIO_OFF_DOUT_C: dout_d[2] = host_wdata_in;
                `LMPIO_OFF_DOUT_D: dout_d[3] = host_wdata_in & `LMPIO_PORTD_MASK;
                `LMPIO_OFF_DIR_A: dir_d[0] = host_wdata_in;
                `LMPIO_OFF_DIR_B: dir_d[1] = host_wdata_in;
                `LMPIO_OFF_DIR_C: dir_d[2] = host_wdata_in;
                `LMPIO_OFF_DIR_D: dir_d[3] = host_wdata_in & `LMPIO_PORTD_MASK;
                `LMPIO_OFF_CTRL_A: ctrl_d[0] = host_wdata_in;
                `LMPIO_OFF_CTRL_B: ctrl_d[1] = host_wdata_in;
                `LMPIO_OFF_MASK_A: mask_d[0] = host_wdata_in;
                `LMPIO_OFF_MASK_B: mask_d[1] = host_wdata_in;
                default: begin
                    // Other offsets store nothing here
                    dout_d = dout_q;
                end
            endcase
        end
    end

    // Everything clears to zero: all pins inputs bar array outputs with no enable term, host I/O mode
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            dout_q <= '0;
            dir_q <= '0;
            ctrl_q <= '0;
            mask_q <= '0;
        end else begin
            dout_q <= dout_d;
            dir_q <= dir_d;
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
        end
    end

    // -------------------------------------------------------------
    // Output cell load selection
    // -------------------------------------------------------------
    // Edge style fires once at strobe release; level style follows
    // the bus for every cycle the strobe stands
    always_comb begin
        if (cfg_edge_load_in) begin
            ld_hit[0] = trail && (wa_q == `LMPIO_OFF_OMC_A);
            ld_hit[1] = trail && (wa_q == `LMPIO_OFF_OMC_B);
            ld_data = wd_q;
        end else begin
            ld_hit[0] = wr_now && (host_addr_in == `LMPIO_OFF_OMC_A);
            ld_hit[1] = wr_now && (host_addr_in == `LMPIO_OFF_OMC_B);
            ld_data = host_wdata_in;
        end
    end

    // -------------------------------------------------------------
    // Output cell flip-flops
    // -------------------------------------------------------------
    genvar m;
    generate
        for (m = 0; m < 16; m = m + 1) begin : g_omc
            // Unmasked host load beats clear, preset and term clock
            always_comb begin
                if (ld_hit[m/8] && !mask_q[m/8][m%8]) begin
                    omc_d[m] = ld_data[m%8];
                end else if (omc_clear_pt_in[m]) begin
                    omc_d[m] = 1'b0;
                end else if (omc_preset_pt_in[m]) begin
                    omc_d[m] = 1'b1;
                end else if (omc_clk_pt_in[m]) begin
                    omc_d[m] = sum[m];
                end else begin
                    omc_d[m] = omc_q[m];
                end
                // A swallowed cell gives nothing to array or pin
                if (consumed[m]) begin
                    fb_d[m] = 1'b0;
                end else begin
                    fb_d[m] = cfg_comb_in[m] ? sum[m] : omc_q[m];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            omc_q <= 16'h0000;
            fb_q <= 16'h0000;
        end else begin
            omc_q <= omc_d;
            fb_q <= fb_d;
        end
    end

    // Feedback reaches the array whether or not a pin uses it
    assign output_logic_cell_out = fb_q;

    // -------------------------------------------------------------
    // Input cells
    // -------------------------------------------------------------
    // One strobe per nibble: A3-0, A7-4, B3-0, B7-4, C
    genvar n;
    generate
        for (n = 0; n < 5; n = n + 1) begin : g_strb
            always_comb begin
                strb[n] = cfg_imc_ale_in[n] ? host_ale_in : imc_pt_in[n];
                strb_d[n] = strb[n];
            end
        end
    endgenerate

    genvar k;
    generate
        for (k = 0; k < 20; k = k + 1) begin : g_imc
            // Port C cells sit on pins 2, 3, 4 and 7
            localparam int PIN = (k < 16) ? k : ((k == 19) ? 23 : (k + 2));
            lmpio_pkg::lmpio_imc_mode_t mode;
            assign mode = lmpio_pkg::lmpio_imc_mode_t'(cfg_imc_mode_in[k*2 +: 2]);
            always_comb begin
                case (mode)
                    lmpio_pkg::LMPIO_IMC_LATCH: begin
                        // Transparent while the strobe is high
                        imc_d[k] = strb[k/4] ? pins[PIN/8][PIN%8] : imc_q[k];
                    end
                    lmpio_pkg::LMPIO_IMC_REG: begin
                        // Captured on the strobe's rising edge
                        imc_d[k] = (strb[k/4] && !strb_q[k/4])
                            ? pins[PIN/8][PIN%8] : imc_q[k];
                    end
                    default: begin
                        imc_d[k] = pins[PIN/8][PIN%8];
                    end
                endcase
            end
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            imc_q <= 20'h00000;
            strb_q <= 5'h00;
        end else begin
            imc_q <= imc_d;
            strb_q <= strb_d;
        end
    end

    assign input_logic_cell_out = imc_q;

    // -------------------------------------------------------------
    // Pin output multiplexer and driver enable
    // -------------------------------------------------------------
    // Array sources: A from group a, B from either group, C from
    // group b, D1-D2 from the external chip selects
    always_comb begin
        pld[0] = fb_q[7:0];
        pld[1] = (fb_q[15:8] & cfg_b_grp_in) | (fb_q[7:0] & ~cfg_b_grp_in);
        pld[2] = fb_q[15:8];
        pld[3] = {5'h00, ext_chip_selects_in, 1'b0};
    end

    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_port
            always_comb begin
                // Ports C and D have no control register
                if (cfg_pld_out_in[p*8 +: 8] == 8'h00 && p >= 2) begin
                    pin_d[p] = dout_q[p];
                end else begin
                    pin_d[p] = dout_q[p];
                end
                if (p < 2) begin
                    pin_d[p] = (alat_q & ctrl_q[p % 2]) | (pin_d[p] & ~ctrl_q[p % 2]);
                end
                pin_d[p] = (pld[p] & cfg_pld_out_in[p*8 +: 8])
                    | (pin_d[p] & ~cfg_pld_out_in[p*8 +: 8]);
                // Enable term OR direction; an array output with no
                // enable term drives from reset onward
                oe_d[p] = oe_pt_in[p*8 +: 8] | dir_q[p]
                    | (cfg_pld_out_in[p*8 +: 8] & ~cfg_oe_def_in[p*8 +: 8]);
                if (p == 3) begin
                    pin_d[p] = pin_d[p] & `LMPIO_PORTD_MASK;
                    oe_d[p] = oe_d[p] & `LMPIO_PORTD_MASK;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pin_q <= '0;
            oe_q <= '0;
        end else begin
            pin_q <= pin_d;
            oe_q <= oe_d;
        end
    end

    assign pin_a_out = pin_q[0];
    assign pin_b_out = pin_q[1];
    assign pin_c_out = pin_q[2];
    assign pin_d_out = pin_q[3][`LMPIO_PORTD_BITS-1:0];
    assign pin_a_oe_out = oe_q[0];
    assign pin_b_oe_out = oe_q[1];
    assign pin_c_oe_out = oe_q[2];
    assign pin_d_oe_out = oe_q[3][`LMPIO_PORTD_BITS-1:0];

    // -------------------------------------------------------------
    // Port readback buffer
    // -------------------------------------------------------------
    // Exactly one source per offset; unmapped or idle reads give zero
    always_comb begin
        rd_d = `LMPIO_RST_BYTE;
        if (port_register_window_select_in && host_rd_in) begin
            case (host_addr_in)
                `LMPIO_OFF_DIN_A: rd_d = pins[0];
                `LMPIO_OFF_DIN_B: rd_d = pins[1];
                `LMPIO_OFF_DIN_C: rd_d = pins[2];
                `LMPIO_OFF_DIN_D: rd_d = pins[3];
                `LMPIO_OFF_DOUT_A: rd_d = dout_q[0];
                `LMPIO_OFF_DOUT_B: rd_d = dout_q[1];
                `LMPIO_OFF_DOUT_C: rd_d = dout_q[2];
                `LMPIO_OFF_DOUT_D: rd_d = dout_q[3];
                `LMPIO_OFF_DIR_A: rd_d = dir_q[0];
                `LMPIO_OFF_DIR_B: rd_d = dir_q[1];
                `LMPIO_OFF_DIR_C: rd_d = dir_q[2];
                `LMPIO_OFF_DIR_D: rd_d = dir_q[3];
                `LMPIO_OFF_CTRL_A: rd_d = ctrl_q[0];
                `LMPIO_OFF_CTRL_B: rd_d = ctrl_q[1];
                `LMPIO_OFF_MASK_A: rd_d = mask_q[0];
                `LMPIO_OFF_MASK_B: rd_d = mask_q[1];
                `LMPIO_OFF_OMC_A: rd_d = omc_q[7:0];
                `LMPIO_OFF_OMC_B: rd_d = omc_q[15:8];
                `LMPIO_OFF_IMC_A: rd_d = imc_q[7:0];
                `LMPIO_OFF_IMC_B: rd_d = imc_q[15:8];
                `LMPIO_OFF_IMC_C: rd_d = {4'h0, imc_q[19:16]};
                default: rd_d = `LMPIO_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rd_q <= `LMPIO_RST_BYTE;
        end else begin
            rd_q <= rd_d;
        end
    end

    assign host_rdata_out = rd_q;
endmodule : lmpio_top

// file: tb/lmpio_pin_model.sv
// Pin partner: resolves each pad from the block's drive and enable.
// Assumes the bench supplies the external level of every undriven pad.
`timescale 1ns/1ps
module lmpio_pin_model #(parameter int W = 8) (
    input wire logic [W-1:0] drv_in, // Block drive
    input wire logic [W-1:0] oe_in, // High while block drives
    input wire logic [W-1:0] ext_in, // Far-side level when released
    output logic [W-1:0] lvl_out
);
    // No pull on these pads, so a released pin shows the far side only
    assign lvl_out = (drv_in & oe_in) | (ext_in & ~oe_in);
endmodule : lmpio_pin_model

// file: tb/lmpio_top_assertions.sv
// Port-level checks of the macrocell and port block.
// Assumes the bench leaves cfg_* static after reset.
`timescale 1ns/1ps
module lmpio_top_assertions (
    input wire logic clk_in, srst_in, port_register_window_select_in, host_rd_in, host_wr_in,
    input wire logic [7:0] host_addr_in, host_wdata_in, host_rdata_out, pin_a_in,
    input wire logic [7:0] pin_a_oe_out, pin_b_oe_out, pin_c_oe_out,
    input wire logic [31:0] oe_pt_in, cfg_oe_def_in, cfg_pld_out_in,
    input wire logic [39:0] cfg_imc_mode_in,
    input wire logic [19:0] input_logic_cell_out
);
    // ----------------------------------------
    // Shared clock and reset
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    logic rd_ok; // Read sampled inside the window
    assign rd_ok = port_register_window_select_in && host_rd_in;
    a_din_read_pins: assert property (rd_ok && host_addr_in == 8'h00 |=>
        host_rdata_out == $past(pin_a_in)) else $error("pin read wrong");
    a_idle_bus_zero: assert property (!rd_ok |=> host_rdata_out == 8'h00)
        else $error("rdata not zero");
    a_unmapped_read: assert property (rd_ok && host_addr_in == 8'h30 |=>
        host_rdata_out == 8'h00) else $error("unmapped read");
    a_portd_narrow: assert property (rd_ok && host_addr_in == 8'h15 |=>
        host_rdata_out[7:3] == 5'h00) else $error("port d wide");
    a_dir_sets_oe: assert property (port_register_window_select_in && host_wr_in &&
        host_addr_in == 8'h06 && host_wdata_in == 8'hff |=> ##1 pin_a_oe_out == 8'hff)
        else $error("dir no drive");
    a_term_sets_oe: assert property (oe_pt_in[8] && cfg_oe_def_in[8] |=> pin_b_oe_out[0])
        else $error("term no drive");
    a_pld_pin_on: assert property (cfg_pld_out_in[16] && !cfg_oe_def_in[16] ##1 1'b1
        |=> pin_c_oe_out[0]) else $error("array pin off");
    a_imc_pass: assert property (cfg_imc_mode_in[3:2] == 2'h0 |=>
        input_logic_cell_out[1] == $past(pin_a_in[1])) else $error("pass cell");
endmodule : lmpio_top_assertions
bind lmpio_top lmpio_top_assertions i_chk (.*);

// file: tb/testbench.sv
// Self-checking bench of the macrocell and port block.
// Assumes edge loading and a static, mostly idle logic-array side.
`timescale 1ns/1ps
module testbench;
    logic clk_in = 0, srst_in = 1, port_register_window_select_in = 0, host_wr_in = 0;
    logic host_rd_in = 0, host_ale_in = 0, cfg_edge_load_in = 1;
    logic [7:0] host_addr_in = '0, host_wdata_in = '0, host_rdata_out, q, cfg_b_grp_in = '0;
    logic [7:0] pin_a_in, pin_b_in, pin_c_in, pin_a_out, pin_b_out, pin_c_out;
    logic [7:0] pin_a_oe_out, pin_b_oe_out, pin_c_oe_out, ea = '0, eb = 8'h03, ec = '0;
    logic [2:0] pin_d_in, pin_d_out, pin_d_oe_out, ed = '0;
    logic [63:0] native_pt_in = '0, cfg_use_native_in = 64'h1;
    logic [15:0] omc_clk_pt_in = '0, omc_preset_pt_in = '0, omc_clear_pt_in = '0;
    logic [15:0] cfg_expand_in = '0, cfg_invert_in = '0, cfg_comb_in = 16'h0003, output_logic_cell_out;
    logic [4:0] imc_pt_in = '0, cfg_imc_ale_in = 5'h04;
    logic [31:0] oe_pt_in = '0, cfg_pld_out_in = 32'h10000, cfg_oe_def_in = 32'h100;
    logic [127:0] cfg_borrow_in = 128'h100; // Cell 1 asks for cell 0 slot 0
    logic [39:0] cfg_imc_mode_in = 40'h0000ff0000; // Cells 8-11 registered
    logic [1:0] ext_chip_selects_in = '0;
    logic [19:0] input_logic_cell_out;
    logic [23:0] rows [6] = '{24'h04a5a5, 24'h073c3c, 24'h13ff07, 24'h220f0f, 24'h23f0f0,
        24'h30ff00}; // Offset, write value, expected readback
    int n_mismatch = 0, n_checks = 0, cyc = 0;
    lmpio_top i_dut (.*);
    lmpio_pin_model #(8) i_pa (.drv_in(pin_a_out), .oe_in(pin_a_oe_out), .ext_in(ea), .lvl_out(pin_a_in));
    lmpio_pin_model #(8) i_pb (.drv_in(pin_b_out), .oe_in(pin_b_oe_out), .ext_in(eb), .lvl_out(pin_b_in));
    lmpio_pin_model #(8) i_pc (.drv_in(pin_c_out), .oe_in(pin_c_oe_out), .ext_in(ec), .lvl_out(pin_c_in));
    lmpio_pin_model #(3) i_pd (.drv_in(pin_d_out), .oe_in(pin_d_oe_out), .ext_in(ed), .lvl_out(pin_d_in));
    // ----------------------------------------
    // Clock, hang guard and bus tasks
    // ----------------------------------------
    initial forever #25 clk_in = ~clk_in;
    // About seventy cycles expected; far margin for slow answers
    always @(posedge clk_in) if (++cyc == 2000) begin
        n_mismatch++;
        complete_run();
    end
    task automatic complete_run();
        if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic chk(string n, logic [7:0] e, logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk
    // One write cycle plus an idle edge so edge loading sees the strobe fall
    task automatic wr(logic [7:0] a, logic [7:0] d);
        {port_register_window_select_in, host_wr_in, host_addr_in, host_wdata_in} = {2'h3, a, d};
        @(posedge clk_in);
        #1 {port_register_window_select_in, host_wr_in} = 2'h0;
        @(posedge clk_in);
        #1;
    endtask : wr
    task automatic rd(logic [7:0] a, output logic [7:0] r);
        {port_register_window_select_in, host_rd_in, host_addr_in} = {2'h3, a};
        @(posedge clk_in);
        #1 {port_register_window_select_in, host_rd_in} = 2'h0;
        r = host_rdata_out;
        // Idle edge so a following request never re-raises in one step
        @(posedge clk_in);
        #1;
    endtask : rd
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk_in);
        #1 srst_in = 0;
        rd(8'h02, q); chk("ctrl_a", 8'h00, q);
        rd(8'h22, q); chk("mask_a", 8'h00, q);
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], q); chk("row", rows[i][7:0], q);
        end
        omc_clear_pt_in = 16'h00ff; // Load must beat a standing clear
        wr(8'h20, 8'hff); rd(8'h20, q); chk("cell_a", 8'hf0, q);
        omc_clear_pt_in = '0;
        wr(8'h21, 8'hff); rd(8'h21, q); chk("cell_b", 8'h0f, q);
        chk("fb_b", 8'h0f, output_logic_cell_out[15:8]);
        wr(8'h06, 8'hff); chk("oe_a", 8'hff, pin_a_oe_out);
        chk("pin_a", 8'ha5, pin_a_out);
        wr(8'h02, 8'hff); {host_ale_in, host_addr_in} = {1'b1, 8'h5a};
        @(posedge clk_in);
        #1 host_ale_in = 0;
        repeat (2) @(posedge clk_in);
        #1 chk("addr_out", 8'h5a, pin_a_out);
        wr(8'h02, 8'h00); wr(8'h06, 8'h00); ea = 8'h3c; // Release pins to far side
        eb = 8'h00; // Registered cells must keep what the strobe took
        repeat (2) @(posedge clk_in);
        #1 rd(8'h00, q); chk("din_a", 8'h3c, q);
        rd(8'h0a, q); chk("imc_a", 8'h3c, q);
        rd(8'h0b, q); chk("imc_b", 8'h03, q);
        wr(8'h15, 8'hff); chk("oe_d", 8'h07, {5'h00, pin_d_oe_out});
        rd(8'h15, q); chk("dir_d", 8'h07, q);
        oe_pt_in[8] = 1;
        native_pt_in[0] = 1; // Cell 0 uses it; cell 1 may not borrow it
        @(posedge clk_in);
        #1 oe_pt_in[8] = 0;
        chk("oe_b", 8'h3d, pin_b_oe_out);
        @(posedge clk_in);
        #1 chk("fb_a", 8'h01, output_logic_cell_out[7:0]);
        complete_run();
    end
endmodule : testbench
